// ==== verilog/dac_ctrl_defines.svh ====
`ifndef DAC_CTRL_DEFINES_SVH
`define DAC_CTRL_DEFINES_SVH
`define IDX_NONE 7'h00
`define IDX_ATT1 7'h01
`define IDX_ATT6 7'h06
`define IDX_MUTE 7'h07
`define IDX_DIS 7'h08
`define IDX_FILT_FMT 7'h09
`define IDX_RST_MISC 7'h0A
`define IDX_ROLLOFF_GRP 7'h0C
`define IDX_STEP_MODE 7'h0D
`define IDX_ATT7 7'h10
`define IDX_ATT8 7'h11
`define IDX_MUTE_HI 7'h12
`define IDX_DIS_HI 7'h13
`define LEVEL_RST 8'hFF
`define LEVEL_TOP 8'hFF
`define MUTE_FLOOR_FINE 8'h80
`define MUTE_FLOOR_WIDE 8'h9A
`define FMT_RST 4'h5
`define ROLLOFF_BIT 5
`define SOFT_RESET_BIT_BIT 7
`define STEP_MODE_BIT 7
`define GRP_ROLLOFF_RST 4'hF
`define SOFT_RESET_BIT_CYCLES 1024
`define RAMP_SAMPLES 8
`endif

// ==== verilog/dac_ctrl_pkg.sv ====
package dac_ctrl_pkg;
  typedef logic [7:0] level_t;
  typedef enum logic [3:0] {
    FMT_RJ24 = 4'h0,
    FMT_RSV1 = 4'h1,
    FMT_RSV2 = 4'h2,
    FMT_RJ16 = 4'h3,
    FMT_I2S = 4'h4,
    FMT_LJ = 4'h5,
    FMT_TDM_I2S = 4'h6,
    FMT_TDM_LJ = 4'h7,
    FMT_DSP_I2S = 4'h8,
    FMT_DSP_LJ = 4'h9
  } audio_format_t;
  typedef enum logic [2:0] {
    FAM_RJ,
    FAM_I2S,
    FAM_LJ,
    FAM_TDM,
    FAM_DSP,
    FAM_BAD
  } format_family_t;
endpackage : dac_ctrl_pkg

// ==== verilog/ramp_if.sv ====
`timescale 1ns/1ps
interface ramp_if;
  logic tick;
  logic wide;
  logic [7:0] target;
  logic [7:0] level;
  logic muted;
  modport ctrl (output tick, output wide, output target, input level, input muted);
  modport ramp (input tick, input wide, input target, output level, output muted);
endinterface : ramp_if

// ==== verilog/level_ramp.sv ====
`timescale 1ns/1ps
`include "dac_ctrl_defines.svh"
module level_ramp (
  input wire logic i_clk,
  input wire logic i_rst,
  ramp_if.ramp r
);
  logic [7:0] level_q;
  logic [7:0] level_d;
  logic [7:0] floor_w;
  logic up_w;
  logic down_w;
  // Codes at or below the floor are all silence
  assign floor_w = r.wide ? `MUTE_FLOOR_WIDE : `MUTE_FLOOR_FINE;
  // Target below floor ramps to floor then jumps straight to target
  assign up_w = r.target > level_q;
  assign down_w = r.target < level_q;
  always_comb begin
    level_d = level_q;
    if (r.tick && up_w) begin
      level_d = (level_q < floor_w) ? floor_w : level_q + 8'h01;
    end else if (r.tick && down_w) begin
      level_d = (level_q <= floor_w) ? r.target : level_q - 8'h01;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) level_q <= `LEVEL_RST;
    else level_q <= level_d;
  end
  assign r.level = level_q;
  assign r.muted = level_q <= floor_w;
endmodule : level_ramp

// ==== verilog/dac_channel_control_regs.sv ====
`timescale 1ns/1ps
`include "dac_ctrl_defines.svh"
module dac_channel_control_regs #(
  parameter int SOFT_RESET_BIT_CYCLES = `SOFT_RESET_BIT_CYCLES,
  parameter int SAMPLE_TICKS = `RAMP_SAMPLES
) (
  input wire logic I_CLK,
  input wire logic I_SOFT_RESET_BIT,
  input wire logic I_WORD_VALID,
  input wire logic [15:0] I_WORD,
  input wire logic I_FS_TICK,
  output logic [63:0] O_LEVEL,
  output logic [7:0] O_CH_MUTED,
  output logic [7:0] O_USE_COMMON_LEVEL,
  output logic [3:0] O_PAIR_SLOW_ROLLOFF,
  output dac_ctrl_pkg::audio_format_t O_FORMAT,
  output dac_ctrl_pkg::format_family_t O_FORMAT_FAMILY,
  output logic O_STEP_WIDE,
  output logic O_SOFT_RESET_BUSY
);
  import dac_ctrl_pkg::*;
  localparam int SW = $clog2(SOFT_RESET_BIT_CYCLES + 1);
  localparam int TW = $clog2(SAMPLE_TICKS + 1);
  logic [7:0] att_q [8];
  logic [7:0] mute_q;
  logic [1:0] mute_hi_q;
  logic [7:0] dis_q;
  logic [1:0] dis_hi_q;
  logic rolloff_q;
  logic [3:0] fmt_q;
  logic [3:0] grp_q;
  logic wide_q;
  logic soft_reset_bit_q;
  logic [SW-1:0] soft_reset_bit_cnt_q;
  logic [TW-1:0] tick_cnt_q;
  logic fs_meta_q;
  logic fs_sync_q;
  logic fs_prev_q;
  logic fs_rise_w;
  logic tick_w;
  logic wr_w;
  logic [6:0] idx_w;
  logic [7:0] dat_w;
  logic clr_w;
  logic [7:0] mute_eff_w;
  logic [7:0] dis_eff_w;
  logic [7:0] lvl_w [8];
  logic [7:0] mut_w;
  format_family_t fam_w;
  ramp_if rif [8] ();
  assign wr_w = I_WORD_VALID && !I_WORD[15];
  assign idx_w = I_WORD[14:8];
  assign dat_w = I_WORD[7:0];
  assign clr_w = I_SOFT_RESET_BIT || soft_reset_bit_q;
  assign fs_rise_w = fs_sync_q && !fs_prev_q;
  assign tick_w = fs_rise_w && (tick_cnt_q == TW'(SAMPLE_TICKS - 1));
  assign mute_eff_w = {mute_q[7] | mute_hi_q[1], mute_q[6] | mute_hi_q[0], mute_q[5:0]};
  assign dis_eff_w = {dis_q[7] | dis_hi_q[1], dis_q[6] | dis_hi_q[0], dis_q[5:0]};
  always_comb begin
    unique case (fmt_q)
      FMT_RJ24, FMT_RJ16: fam_w = FAM_RJ;
      FMT_I2S: fam_w = FAM_I2S;
      FMT_LJ: fam_w = FAM_LJ;
      FMT_TDM_I2S, FMT_TDM_LJ: fam_w = FAM_TDM;
      FMT_DSP_I2S, FMT_DSP_LJ: fam_w = FAM_DSP;
      default: fam_w = FAM_BAD;
    endcase
  end
  always_ff @(posedge I_CLK) begin
    fs_meta_q <= I_FS_TICK;
    fs_sync_q <= fs_meta_q;
    fs_prev_q <= fs_sync_q;
  end
  always_ff @(posedge I_CLK) begin
    if (I_SOFT_RESET_BIT) tick_cnt_q <= '0;
    else if (tick_w) tick_cnt_q <= '0;
    else if (fs_rise_w) tick_cnt_q <= tick_cnt_q + TW'(1);
  end
  always_ff @(posedge I_CLK) begin
    if (I_SOFT_RESET_BIT) begin
      soft_reset_bit_q <= 1'b0;
      soft_reset_bit_cnt_q <= '0;
    end else if (soft_reset_bit_q) begin
      soft_reset_bit_cnt_q <= soft_reset_bit_cnt_q + SW'(1);
      if (soft_reset_bit_cnt_q == SW'(SOFT_RESET_BIT_CYCLES - 1)) begin
        soft_reset_bit_q <= 1'b0;
        soft_reset_bit_cnt_q <= '0;
      end
    end else if (wr_w && idx_w == `IDX_RST_MISC && dat_w[`SOFT_RESET_BIT_BIT]) begin
      soft_reset_bit_q <= 1'b1;
    end
  end
  // Index 0 and unlisted indices match nothing, so write is dropped
  always_ff @(posedge I_CLK) begin
    if (clr_w) begin
      mute_q <= 8'h00;
      mute_hi_q <= 2'h0;
      dis_q <= 8'h00;
      dis_hi_q <= 2'h0;
      rolloff_q <= 1'b0;
      fmt_q <= `FMT_RST;
      grp_q <= `GRP_ROLLOFF_RST;
      wide_q <= 1'b0;
    end else if (wr_w) begin
      if (idx_w == `IDX_MUTE) mute_q <= dat_w;
      if (idx_w == `IDX_MUTE_HI) mute_hi_q <= dat_w[1:0];
      if (idx_w == `IDX_DIS) dis_q <= dat_w;
      if (idx_w == `IDX_DIS_HI) dis_hi_q <= dat_w[1:0];
      if (idx_w == `IDX_FILT_FMT) begin
        rolloff_q <= dat_w[`ROLLOFF_BIT];
        fmt_q <= dat_w[3:0];
      end
      if (idx_w == `IDX_ROLLOFF_GRP) grp_q <= dat_w[3:0];
      if (idx_w == `IDX_STEP_MODE) wide_q <= dat_w[`STEP_MODE_BIT];
    end
  end
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ch
      localparam logic [6:0] CH_IDX = (g < 6) ? 7'(g + 1) : 7'(g + 10);
      always_ff @(posedge I_CLK) begin
        if (clr_w) att_q[g] <= `LEVEL_RST;
        else if (wr_w && idx_w == CH_IDX) att_q[g] <= dat_w;
      end
      // Mute drives target to zero; release restores programmed code
      assign rif[g].target = mute_eff_w[g] ? 8'h00 : att_q[g];
      assign rif[g].tick = tick_w;
      assign rif[g].wide = wide_q;
      assign lvl_w[g] = rif[g].level;
      assign mut_w[g] = rif[g].muted;
      level_ramp level_ramp_i (
        .i_clk(I_CLK),
        .i_rst(clr_w),
        .r(rif[g])
      );
      always_ff @(posedge I_CLK) begin
        if (I_SOFT_RESET_BIT) begin
          O_LEVEL[g*8 +: 8] <= `LEVEL_RST;
          O_CH_MUTED[g] <= 1'b0;
          O_USE_COMMON_LEVEL[g] <= 1'b0;
        end else begin
          O_LEVEL[g*8 +: 8] <= lvl_w[g];
          O_CH_MUTED[g] <= mut_w[g];
          O_USE_COMMON_LEVEL[g] <= dis_eff_w[g];
        end
      end
    end
  endgenerate
  always_ff @(posedge I_CLK) begin
    if (I_SOFT_RESET_BIT) begin
      O_PAIR_SLOW_ROLLOFF <= 4'h0;
      O_FORMAT <= FMT_LJ;
      O_FORMAT_FAMILY <= FAM_LJ;
      O_STEP_WIDE <= 1'b0;
      O_SOFT_RESET_BUSY <= 1'b0;
    end else begin
      O_PAIR_SLOW_ROLLOFF <= rolloff_q ? grp_q : 4'h0;
      O_FORMAT <= audio_format_t'(fmt_q);
      O_FORMAT_FAMILY <= fam_w;
      O_STEP_WIDE <= wide_q;
      O_SOFT_RESET_BUSY <= soft_reset_bit_q;
    end
  end
endmodule : dac_channel_control_regs

// ==== bench/host_ctrl_model.sv ====
`timescale 1ns/1ps
module host_ctrl_model (
  input wire logic i_clk,
  output logic o_valid,
  output logic [15:0] o_word
);
  initial begin
    o_valid = 1'b0;
    o_word = 16'h0000;
  end
  task automatic send(input logic b15, input logic [6:0] idx, input logic [7:0] dat);
    @(negedge i_clk);
    o_word = {b15, idx, dat};
    o_valid = 1'b1;
    @(negedge i_clk);
    o_valid = 1'b0;
    o_word = ~o_word;
    repeat (3) @(negedge i_clk);
  endtask : send
endmodule : host_ctrl_model

// ==== bench/dac_ctrl_properties.sv ====
`timescale 1ns/1ps
module dac_ctrl_properties #(parameter int SOFT_RESET_BIT_CYCLES = 1024) (
  input wire logic I_CLK,
  input wire logic I_SOFT_RESET_BIT,
  input wire logic I_WORD_VALID,
  input wire logic [15:0] I_WORD,
  input wire logic [63:0] O_LEVEL,
  input wire logic [7:0] O_CH_MUTED,
  input wire logic [7:0] O_USE_COMMON_LEVEL,
  input wire logic [3:0] O_PAIR_SLOW_ROLLOFF,
  input wire dac_ctrl_pkg::audio_format_t O_FORMAT,
  input wire dac_ctrl_pkg::format_family_t O_FORMAT_FAMILY,
  input wire logic O_STEP_WIDE,
  input wire logic O_SOFT_RESET_BUSY
);
  import dac_ctrl_pkg::*;
  logic [11:0] cnt_q;
  logic [7:0] l0;
  logic wr;
  format_family_t fam;
  logic [3:0] f;
  assign l0 = O_LEVEL[7:0];
  assign f = O_FORMAT;
  assign wr = I_WORD_VALID && !I_WORD[15] && !O_SOFT_RESET_BUSY;
  assign fam = f <= 4'h3 ? ((f == 4'h1 || f == 4'h2) ? FAM_BAD : FAM_RJ) : f == 4'h4 ? FAM_I2S :
    f == 4'h5 ? FAM_LJ : f <= 4'h7 ? FAM_TDM : f <= 4'h9 ? FAM_DSP : FAM_BAD;
  // Busy cycles seen so far
  always_ff @(posedge I_CLK) cnt_q <= (I_SOFT_RESET_BIT || !O_SOFT_RESET_BUSY) ? 12'h000 : cnt_q + 12'h001;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SOFT_RESET_BIT);
  AST_STEP: assert property (!O_SOFT_RESET_BUSY && $changed(l0) && $past(l0) > 8'h9A |->
    l0 - $past(l0) == 8'h01 || $past(l0) - l0 == 8'h01 || l0 == 8'hFF) else $error("bad step");
  AST_MUTED: assert property ($stable(l0) && $stable(O_STEP_WIDE) |->
    O_CH_MUTED[0] == (l0 <= (O_STEP_WIDE ? 8'h9A : 8'h80))) else $error("bad mute flag");
  AST_FAMILY: assert property ($stable(f) |-> O_FORMAT_FAMILY == fam)
    else $error("bad format family");
  AST_IGNORED: assert property (!$past(I_WORD_VALID) && I_WORD_VALID && !O_SOFT_RESET_BUSY &&
    (I_WORD[15] || I_WORD[14:8] == 7'h00) |=> $stable(O_USE_COMMON_LEVEL) [*2])
    else $error("ignored word acted");
  AST_DISABLE: assert property (wr && I_WORD[14:8] == 7'h08 |->
    ##2 O_USE_COMMON_LEVEL[5:0] == $past(I_WORD[5:0], 2)) else $error("bad disable bits");
  AST_OR_COPY: assert property (wr && I_WORD[14:8] == 7'h13 && I_WORD[0] |->
    ##2 O_USE_COMMON_LEVEL[6]) else $error("upper copy ignored");
  AST_FLT_OFF: assert property (wr && I_WORD[14:8] == 7'h09 && !I_WORD[5] |->
    ##2 O_PAIR_SLOW_ROLLOFF == 4'h0) else $error("pair roll-off not cleared");
  AST_SOFT_RESET_BIT_LEN: assert property ($fell(O_SOFT_RESET_BUSY) |-> cnt_q == SOFT_RESET_BIT_CYCLES[11:0])
    else $error("bad soft reset length");
  AST_SOFT_RESET_BIT_DEF: assert property ($fell(O_SOFT_RESET_BUSY) |-> O_FORMAT == FMT_LJ &&
    O_USE_COMMON_LEVEL == 8'h00 && !O_STEP_WIDE) else $error("soft reset left state");
  cover property ($fell(O_SOFT_RESET_BUSY));
  cover property ($rose(O_CH_MUTED[0]));
  cover property (O_USE_COMMON_LEVEL == 8'hFF);
endmodule : dac_ctrl_properties
bind dac_channel_control_regs dac_ctrl_properties #(.SOFT_RESET_BIT_CYCLES(SOFT_RESET_BIT_CYCLES)) props_i (
  .I_CLK(I_CLK), .I_SOFT_RESET_BIT(I_SOFT_RESET_BIT), .I_WORD_VALID(I_WORD_VALID), .I_WORD(I_WORD),
  .O_LEVEL(O_LEVEL), .O_CH_MUTED(O_CH_MUTED), .O_USE_COMMON_LEVEL(O_USE_COMMON_LEVEL),
  .O_PAIR_SLOW_ROLLOFF(O_PAIR_SLOW_ROLLOFF), .O_FORMAT(O_FORMAT),
  .O_FORMAT_FAMILY(O_FORMAT_FAMILY), .O_STEP_WIDE(O_STEP_WIDE),
  .O_SOFT_RESET_BUSY(O_SOFT_RESET_BUSY));

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import dac_ctrl_pkg::*;
  logic clk = 1'b0;
  logic soft_reset_bit = 1'b1;
  logic [2:0] fsc = 3'h0;
  logic valid, wide, busy;
  logic [15:0] word;
  logic [63:0] level;
  logic [7:0] muted, usel;
  logic [3:0] pair;
  audio_format_t fmt;
  format_family_t fam;
  int n_errors = 0;
  int compares = 0;
  localparam format_family_t EXP_FAM[10] = '{FAM_RJ, FAM_BAD, FAM_BAD, FAM_RJ, FAM_I2S,
    FAM_LJ, FAM_TDM, FAM_TDM, FAM_DSP, FAM_DSP};
  always #2 clk = ~clk;
  always @(negedge clk) fsc <= fsc + 3'h1;
  host_ctrl_model host_ctrl_model_i (.i_clk(clk), .o_valid(valid), .o_word(word));
  dac_channel_control_regs #(.SOFT_RESET_BIT_CYCLES(16), .SAMPLE_TICKS(2)) dac_channel_control_regs_i (
    .I_CLK(clk), .I_SOFT_RESET_BIT(soft_reset_bit), .I_WORD_VALID(valid), .I_WORD(word), .I_FS_TICK(fsc[2]),
    .O_LEVEL(level), .O_CH_MUTED(muted), .O_USE_COMMON_LEVEL(usel),
    .O_PAIR_SLOW_ROLLOFF(pair), .O_FORMAT(fmt), .O_FORMAT_FAMILY(fam), .O_STEP_WIDE(wide),
    .O_SOFT_RESET_BUSY(busy));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input logic [6:0] i, input logic [7:0] d);
    host_ctrl_model_i.send(1'b0, i, d);
  endtask : w
  task automatic t_levels();
    logic [6:0] idx[8] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h10, 7'h11};
    for (int c = 0; c < 8; c++) w(idx[c], 8'hF8 - c[7:0]);
    repeat (300) @(negedge clk);
    for (int c = 0; c < 8; c++) chk(level[c*8+:8], 8'hF8 - c[7:0]);
  endtask : t_levels
  task automatic t_mute();
    w(7'h07, 8'h01);
    w(7'h12, 8'h01);
    repeat (2600) @(negedge clk);
    chk({muted[0], muted[6], level[7:0], level[55:48]}, 18'h30000);
    w(7'h07, 8'h00);
    repeat (2600) @(negedge clk);
    chk({muted[6], level[7:0]}, 9'h1F8);
    w(7'h12, 8'h00);
    repeat (2600) @(negedge clk);
    chk(level[55:48], 8'hF2);
  endtask : t_mute
  task automatic t_regs();
    w(7'h08, 8'h3F);
    w(7'h13, 8'h03);
    chk(usel, 8'hFF);
    w(7'h08, 8'h00);
    chk(usel, 8'hC0);
    w(7'h13, 8'h00);
    host_ctrl_model_i.send(1'b1, 7'h08, 8'hFF);
    w(7'h00, 8'hFF);
    w(7'h0E, 8'hFF);
    chk(usel, 8'h00);
    for (int f = 0; f < 10; f++) begin
      w(7'h09, f[7:0]);
      chk({fmt, fam}, {f[3:0], EXP_FAM[f]});
    end
    w(7'h09, 8'h25);
    chk(pair, 4'hF);
    w(7'h0C, 8'h05);
    chk(pair, 4'h5);
    w(7'h09, 8'h05);
    chk(pair, 4'h0);
    w(7'h0D, 8'h80);
    chk(wide, 1'b1);
    // Wide range: ramp channel 1 down to the wide mute floor
    w(7'h01, 8'h9A);
    repeat (1600) @(negedge clk);
    chk({muted[0], level[7:0]}, 9'h19A);
  endtask : t_regs
  task automatic t_soft_reset_bit();
    w(7'h0A, 8'h80);
    w(7'h08, 8'hFF);
    for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
    repeat (2) @(negedge clk);
    chk({usel, fmt, wide, busy}, {8'h00, FMT_LJ, 2'b00});
    repeat (300) @(negedge clk);
    chk(level, {8{8'hFF}});
  endtask : t_soft_reset_bit
  task automatic final_report();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    #80000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (8) @(negedge clk);
    soft_reset_bit = 1'b0;
    @(negedge clk);
    chk(level, {8{8'hFF}});
    chk({muted, usel, fmt, fam, pair, wide, busy}, {16'h0, FMT_LJ, FAM_LJ, 6'h0});
    t_levels();
    t_mute();
    t_regs();
    t_soft_reset_bit();
    final_report();
  end
endmodule : tb_top
